// file: core/cvsf_defines.svh
// Offsets, bit positions, masks, reset values and temperature hysteresis of the converter status flags
`ifndef CVSF_DEFINES_SVH
`define CVSF_DEFINES_SVH

// Command codes of the status bytes
`define CVSF_INPUT_STATUS_CMD         8'h7c
`define CVSF_TEMPERATURE_STATUS_CMD   8'h7d
`define CVSF_COMMUNICATION_STATUS_CMD 8'h7e
`define CVSF_VENDOR_FAULT_STATUS_CMD  8'h80

// Bit positions
`define CVSF_IN_LOW_SUPPLY_BIT 4
`define CVSF_TEMP_FAULT_BIT    7
`define CVSF_TEMP_WARN_BIT     6
`define CVSF_COMM_BAD_CMD_BIT  7
`define CVSF_COMM_BAD_DATA_BIT 6
`define CVSF_COMM_PEC_BIT      5
`define CVSF_COMM_MEM_BIT      4
`define CVSF_COMM_OTHER_BIT    1
`define CVSF_VF_DIE_TSD_BIT    7
`define CVSF_VF_ZERO_BIT       6
`define CVSF_VF_MULTI_BIT      5
`define CVSF_VF_BOOT_STRAP_BIT 4
`define CVSF_VF_SS_STRAP_BIT   3
`define CVSF_VF_RESET_VOUT_BIT 2
`define CVSF_VF_FOLLOWER_BIT   1
`define CVSF_VF_SYNC_BIT       0

// Writable bit masks of each byte
`define CVSF_INPUT_W1C_MASK  8'h10
`define CVSF_TEMP_W1C_MASK   8'hc0
`define CVSF_COMM_W1C_MASK   8'hf2
`define CVSF_VENDOR_W1C_MASK 8'h98

// Reset values
`define CVSF_INPUT_RESET  8'h10
`define CVSF_ZERO_RESET   8'h00

// Temperature hysteresis before an overtemperature flag may stay clear, in degrees C
`define CVSF_TEMP_HYST_C 8'h14

`endif

// file: core/cvsf_pkg.sv
// Types shared by the converter status flag logic
package cvsf_pkg;

    // Host access to a status byte
    typedef struct packed {
        logic       wr;
        logic [7:0] cmd;
        logic [7:0] data;
    } cvsf_host_wr_t;

    // One-shot communication fault events
    typedef struct packed {
        logic bad_cmd;
        logic bad_data;
        logic pec_fail;
        logic mem_fault;
        logic other;
    } cvsf_comm_evt_t;

    // Supply tracking states, one-hot
    typedef enum logic [1:0] {
        CVSF_POWERUP = 2'b01,
        CVSF_RUNNING = 2'b10
    } cvsf_supply_state_t;

endpackage

// file: core/cvsf_temp_flag.sv
// One latched overtemperature flag with clear-and-reassert hysteresis
`timescale 1ns/10ps
`default_nettype none
`include "cvsf_defines.svh"

module cvsf_temp_flag (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] temp_i,
    input  wire logic [7:0] limit_i,
    input  wire logic       clear_i,
    output logic            flag_o
);
    logic [8:0] rearm_level;
    wire        at_limit;
    wire        still_hot;
    logic       cleared_hot;

    // Signed-safe compare: limit minus hysteresis may underflow, so widen
    assign rearm_level = {1'b0, limit_i} - {1'b0, `CVSF_TEMP_HYST_C};
    assign at_limit    = temp_i >= limit_i;                           // [R5]
    assign still_hot   = rearm_level[8] ? 1'b1 : ({1'b0, temp_i} > rearm_level); // [R6]

    // Set wins over clear; a flag cleared while still hot comes back next cycle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_o      <= 1'b0;
            cleared_hot <= 1'b0;
        end else begin
            if (at_limit || cleared_hot) begin
                flag_o <= 1'b1;                                        // [R5] [R6]
            end else if (clear_i) begin
                flag_o <= 1'b0;
            end
            cleared_hot <= clear_i && flag_o && still_hot && !at_limit; // [R6]
        end
    end

    cleared_reasserts_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R6]
        (clear_i && flag_o && still_hot && !at_limit) |=> ##1 flag_o)
        else $error("hot flag not reasserted");
endmodule
`default_nettype wire

// file: core/cvsf_fsm_check.sv
// Legality check of the one-hot operation state vector
`timescale 1ns/10ps
`default_nettype none

module cvsf_fsm_check (
    input  wire logic [7:0] state_i,
    output logic            zero_o,
    output logic            multi_o
);
    // Clearing the lowest set bit leaves a nonzero value only if at least two bits were high
    assign zero_o  = state_i == 8'h00;                                 // [R12]
    assign multi_o = (state_i & (state_i - 8'h01)) != 8'h00;           // [R13]
endmodule
`default_nettype wire

// file: core/cvsf_status.sv
// Converter status flag bytes: input, temperature, communication and vendor status
// What this block does
// (R1) Input undervoltage flag is set at power-up until supply first exceeds turn-on level.
// (R2) That power-up indication is unlatched and never raises the alert.
// (R3) After first turn-on, any drop below turn-off level latches the flag and alerts.
// (R4) Writable flags clear by host write; stored mask bits gate them from the alert.
// (R5) Overtemperature fault and warning set when temperature reaches their limits.
// (R6) A cleared overtemperature flag returns unless temperature fell 20 C below limit.
// (R7) Communication bit 7 sets on an invalid or unsupported command.
// (R8) Communication bit 6 sets on invalid or unsupported data.
// (R9) Communication bit 5 sets on a failed packet error check.
// (R10) Communication bit 4 sets on memory fault, bit 1 on other faults.
// (R11) Vendor bit 7 sets when die temperature exceeds thermal shutdown.
// (R12) Vendor bit 6 sets on an all-zero operation state, no alert.
// (R13) Vendor bit 5 sets when several operation state bits are high, no alert.
// (R14) Vendor bit 4 sets on boot voltage strap failure and raises the alert.
// (R15) A loop master stays off on boot voltage strap failure unless the override option is set.
// (R16) Strap failure flags clear only by clear-faults or writing 1.
// (R17) Vendor bit 3 sets on soft-start strap failure, information only.
// (R18) A loop follower holds both strap failure flags at zero.
// (R19) Vendor bit 2 shows power-good pin low with boot voltage reload, no alert.
// (R20) Vendor bit 1 shows whether this device is the loop follower.
// (R21) Vendor bit 0 is a live sync fault indicator without alert.
// (R22) Writing 1 clears a flag; writing 0 leaves it unchanged.
// (R23) Alert asserts while any latched, alert-capable, unmasked flag is set.
`timescale 1ns/10ps
`default_nettype none
`include "cvsf_defines.svh"

module cvsf_status (
    input  wire logic                    clock_i,
    input  wire logic                    resetn_i,
    // Host write of a status byte and the clear-faults command
    input  wire cvsf_pkg::cvsf_host_wr_t host_wr_i,
    input  wire logic                    clear_faults_i,
    // Read selection, answered next cycle
    input  wire logic [7:0]              rd_cmd_i,
    output logic [7:0]                   rd_data_o,
    // Alert mask bytes held in nonvolatile memory
    input  wire logic [7:0]              input_mask_i,
    input  wire logic [7:0]              temp_mask_i,
    input  wire logic [7:0]              comm_mask_i,
    input  wire logic [7:0]              vendor_mask_i,
    // Analog status
    input  wire logic                    analog_supply_above_on_i,
    input  wire logic                    analog_supply_below_off_i,
    input  wire logic [7:0]              ext_temp_i,
    input  wire logic [7:0]              overtemperature_fault_level_i,
    input  wire logic [7:0]              overtemperature_warning_level_i,
    input  wire logic                    die_over_thermal_shutdown_i,
    // Communication events
    input  wire cvsf_pkg::cvsf_comm_evt_t comm_evt_i,
    // Operation state vector, one-hot when healthy
    input  wire logic [7:0]              op_state_i,
    // Strap detection
    input  wire logic                    boot_strap_fail_i,
    input  wire logic                    soft_start_strap_fail_i,
    input  wire logic                    drive_on_invalid_select_enable_i,
    input  wire logic                    loop_follower_i,
    input  wire logic                    reset_power_good_pin_low_i,
    input  wire logic                    boot_voltage_reload_req_i,
    input  wire logic                    sync_fault_i,
    // Results
    output logic                         smbus_alert_o,
    output logic                         stage_enable_ok_o,
    output logic [7:0]                   input_status_o,
    output logic [7:0]                   temperature_status_o,
    output logic [7:0]                   communication_status_o,
    output logic [7:0]                   vendor_fault_status_o
);
    cvsf_pkg::cvsf_supply_state_t supply_state;
    cvsf_pkg::cvsf_supply_state_t next_supply_state;
    logic       low_supply;
    logic       low_supply_latched;
    logic [7:0] comm_flags;
    logic [4:0] vendor_latched;
    logic       boot_fail_seen;
    logic       temp_fault;
    logic       temp_warn;
    logic       fsm_zero;
    logic       fsm_multi;

    // Write decode: one clear mask per byte, clear-faults clears every writable bit
    wire [7:0] wr_data     = host_wr_i.data;
    wire       wr_input    = host_wr_i.wr && host_wr_i.cmd == `CVSF_INPUT_STATUS_CMD;
    wire       wr_temp     = host_wr_i.wr && host_wr_i.cmd == `CVSF_TEMPERATURE_STATUS_CMD;
    wire       wr_comm     = host_wr_i.wr && host_wr_i.cmd == `CVSF_COMMUNICATION_STATUS_CMD;
    wire       wr_vendor   = host_wr_i.wr && host_wr_i.cmd == `CVSF_VENDOR_FAULT_STATUS_CMD;
    wire [7:0] clr_input   = ({8{clear_faults_i}} | ({8{wr_input}} & wr_data))
                             & `CVSF_INPUT_W1C_MASK;                   // [R22]
    wire [7:0] clr_temp    = ({8{clear_faults_i}} | ({8{wr_temp}} & wr_data))
                             & `CVSF_TEMP_W1C_MASK;                    // [R22]
    wire [7:0] clr_comm    = ({8{clear_faults_i}} | ({8{wr_comm}} & wr_data))
                             & `CVSF_COMM_W1C_MASK;                    // [R4] [R22]
    wire [7:0] clr_vendor  = ({8{clear_faults_i}} | ({8{wr_vendor}} & wr_data))
                             & `CVSF_VENDOR_W1C_MASK;                  // [R16] [R22]

    // Supply tracking: power-up phase ends the first time the supply passes turn-on
    always_comb begin
        next_supply_state = supply_state;
        case (supply_state)
            cvsf_pkg::CVSF_POWERUP: begin
                if (analog_supply_above_on_i) begin
                    next_supply_state = cvsf_pkg::CVSF_RUNNING;        // [R1]
                end
            end
            cvsf_pkg::CVSF_RUNNING: begin
                next_supply_state = cvsf_pkg::CVSF_RUNNING;
            end
            default: begin
                next_supply_state = cvsf_pkg::CVSF_POWERUP;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            supply_state <= cvsf_pkg::CVSF_POWERUP;
        end else begin
            supply_state <= next_supply_state;
        end
    end

    // Power-up indication is live and unlatched; later drops latch and alert
    wire in_powerup = supply_state == cvsf_pkg::CVSF_POWERUP;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_supply_latched <= 1'b0;
        end else if (!in_powerup && analog_supply_below_off_i) begin
            low_supply_latched <= 1'b1;                                // [R3]
        end else if (clr_input[`CVSF_IN_LOW_SUPPLY_BIT]) begin
            low_supply_latched <= 1'b0;                                // [R4]
        end
    end
    // Host cannot clear the power-up indication; it tracks the supply only
    wire low_supply_now = (in_powerup && !analog_supply_above_on_i)    // [R1] [R2]
                          || low_supply_latched;

    // Overtemperature flags with hysteresis on re-arm
    cvsf_temp_flag u_temp_fault (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .temp_i   (ext_temp_i),
        .limit_i  (overtemperature_fault_level_i),
        .clear_i  (clr_temp[`CVSF_TEMP_FAULT_BIT]),
        .flag_o   (temp_fault)
    );
    cvsf_temp_flag u_temp_warn (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .temp_i   (ext_temp_i),
        .limit_i  (overtemperature_warning_level_i),
        .clear_i  (clr_temp[`CVSF_TEMP_WARN_BIT]),
        .flag_o   (temp_warn)
    );

    // Operation state legality
    cvsf_fsm_check u_fsm_check (
        .state_i  (op_state_i),
        .zero_o   (fsm_zero),
        .multi_o  (fsm_multi)
    );

    // Communication event vector in bit order; set wins over clear
    wire [7:0] comm_set = {comm_evt_i.bad_cmd,                         // [R7]
                           comm_evt_i.bad_data,                        // [R8]
                           comm_evt_i.pec_fail,                        // [R9]
                           comm_evt_i.mem_fault,                       // [R10]
                           2'b00,
                           comm_evt_i.other,                           // [R10]
                           1'b0};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_comm
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    comm_flags[gi] <= 1'b0;
                end else begin
                    comm_flags[gi] <= comm_set[gi] | (comm_flags[gi] & ~clr_comm[gi]); // [R22]
                end
            end
        end
    endgenerate

    // Vendor latched flags: die shutdown, zero, multi, boot strap, soft-start strap
    wire [4:0] vendor_set = {die_over_thermal_shutdown_i,             // [R11]
                             fsm_zero,                                 // [R12]
                             fsm_multi,                                // [R13]
                             boot_strap_fail_i,                        // [R14]
                             soft_start_strap_fail_i};                 // [R17]
    // Zero and multi flags are read-only, so only reset clears them
    wire [4:0] vendor_clr = {clr_vendor[`CVSF_VF_DIE_TSD_BIT], 2'b00,
                             clr_vendor[`CVSF_VF_BOOT_STRAP_BIT],
                             clr_vendor[`CVSF_VF_SS_STRAP_BIT]};      // [R16]
    // A follower forces the strap flags low regardless of events
    wire [4:0] vendor_hold = {3'b111, {2{~loop_follower_i}}};          // [R18]
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vendor_latched <= 5'h00;
        end else begin
            vendor_latched <= (vendor_set | (vendor_latched & ~vendor_clr)) & vendor_hold;
        end
    end

    // Boot strap failure disables a master until reset, unless the option overrides it
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boot_fail_seen <= 1'b0;
        end else if (boot_strap_fail_i && !loop_follower_i) begin
            boot_fail_seen <= 1'b1;                                    // [R15]
        end
    end

    // Assemble the status bytes; live bits come straight from their inputs
    wire [7:0] next_input  = {3'b000, low_supply_now, 4'h0};
    wire [7:0] next_temp   = {temp_fault, temp_warn, 6'h00};
    wire [7:0] next_vendor = {vendor_latched,
                              reset_power_good_pin_low_i && boot_voltage_reload_req_i, // [R19]
                              loop_follower_i,                         // [R20]
                              sync_fault_i};                           // [R21]

    // Alert sources exclude the power-up indication and every informational bit
    wire [7:0] alert_input  = {3'b000, low_supply_latched, 4'h0} & ~input_mask_i; // [R2] [R3]
    wire [7:0] alert_temp   = next_temp & ~temp_mask_i & `CVSF_TEMP_W1C_MASK;     // [R4]
    wire [7:0] alert_comm   = comm_flags & ~comm_mask_i & `CVSF_COMM_W1C_MASK;    // [R4]
    wire [7:0] alert_vendor = next_vendor & ~vendor_mask_i & 8'h90;   // [R12] [R13] [R14] [R17]
    wire       next_alert   = |{alert_input, alert_temp, alert_comm, alert_vendor}; // [R23]

    wire [7:0] next_rd = (rd_cmd_i == `CVSF_INPUT_STATUS_CMD)         ? next_input :
                         (rd_cmd_i == `CVSF_TEMPERATURE_STATUS_CMD)   ? next_temp :
                         (rd_cmd_i == `CVSF_COMMUNICATION_STATUS_CMD) ? comm_flags :
                         (rd_cmd_i == `CVSF_VENDOR_FAULT_STATUS_CMD)  ? next_vendor :
                         8'h00;

    // Output registers; input byte resets showing the power-up indication
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            input_status_o         <= `CVSF_INPUT_RESET;
            temperature_status_o   <= `CVSF_ZERO_RESET;
            communication_status_o <= `CVSF_ZERO_RESET;
            vendor_fault_status_o  <= `CVSF_ZERO_RESET;
            rd_data_o              <= `CVSF_ZERO_RESET;
            smbus_alert_o          <= 1'b0;
            stage_enable_ok_o      <= 1'b0;
        end else begin
            input_status_o         <= next_input;
            temperature_status_o   <= next_temp;
            communication_status_o <= comm_flags;
            vendor_fault_status_o  <= next_vendor;
            rd_data_o              <= next_rd;
            smbus_alert_o          <= next_alert;                      // [R23]
            stage_enable_ok_o      <= loop_follower_i || !(boot_fail_seen || boot_strap_fail_i)
                                      || drive_on_invalid_select_enable_i; // [R15]
        end
    end

    // Bytes are registered, so a latched set shows two edges after its event
    powerup_low_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R1]
        (in_powerup && !analog_supply_above_on_i) |=> input_status_o[4])
        else $error("power-up low supply not shown");
    powerup_no_alert_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R2]
        (in_powerup && !(|alert_comm) && !(|alert_temp) && !(|alert_vendor))
        |=> !smbus_alert_o)
        else $error("alert during power-up");
    drop_latches_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R3]
        (!in_powerup && analog_supply_below_off_i) |=> ##1 input_status_o[4])
        else $error("supply drop not latched");
    bad_cmd_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R7]
        comm_evt_i.bad_cmd |=> ##1 communication_status_o[7])
        else $error("bad command not flagged");
    bad_data_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R8]
        comm_evt_i.bad_data |=> ##1 communication_status_o[6])
        else $error("bad data not flagged");
    pec_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R9]
        comm_evt_i.pec_fail |=> ##1 communication_status_o[5])
        else $error("pec failure not flagged");
    mem_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R10]
        comm_evt_i.mem_fault |=> ##1 communication_status_o[4])
        else $error("memory fault not flagged");
    die_tsd_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R11]
        die_over_thermal_shutdown_i |=> ##1 vendor_fault_status_o[7])
        else $error("die shutdown not flagged");
    strap_alert_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R14]
        (boot_strap_fail_i && !loop_follower_i && !vendor_mask_i[4]) |=> ##1 smbus_alert_o)
        else $error("strap failure without alert");
    follower_strap_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R18]
        $past(loop_follower_i) |-> vendor_latched[1:0] == 2'b00)
        else $error("follower strap flag set");
    sync_live_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R21]
        sync_fault_i |=> vendor_fault_status_o[0])
        else $error("sync fault not shown");
    write_zero_keeps_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R22]
        (wr_comm && !clear_faults_i && !wr_data[5] && comm_flags[5]) |=> comm_flags[5])
        else $error("write of zero cleared flag");
    multi_no_alert_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R13]
        (fsm_multi && !(|alert_input) && !(|alert_temp) && !(|alert_comm)
         && !(|alert_vendor)) |=> !smbus_alert_o)
        else $error("informational flag raised alert");
    master_held_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [R15]
        (boot_strap_fail_i && !loop_follower_i && !drive_on_invalid_select_enable_i)
        |=> !stage_enable_ok_o)
        else $error("master enabled after strap failure");
endmodule
`default_nettype wire

// file: verification/cvsf_host_model.sv
// Host controller model that writes, clears and selects status bytes
`timescale 1ns/10ps
`default_nettype none

module cvsf_host_model (
    input  wire logic                    clock_i,
    output var cvsf_pkg::cvsf_host_wr_t  host_wr_o,
    output var logic                     clear_faults_o,
    output var logic [7:0]               rd_cmd_o
);
    // Idle from time zero so the block never sees an unknown request
    initial begin
        host_wr_o = '0;
        clear_faults_o = 1'b0;
        rd_cmd_o = 8'h00;
    end

    // One-cycle write; ones clear flags, zeros leave them alone
    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
        host_wr_o <= '{wr: 1'b1, cmd: cmd, data: data};
        @(negedge clock_i);
        host_wr_o <= '0;
    endtask

    // Clear-faults command held for exactly one cycle
    task automatic clear_faults();
        clear_faults_o <= 1'b1;
        @(negedge clock_i);
        clear_faults_o <= 1'b0;
    endtask

    // Byte select; the answer is registered, so one edge must pass
    task automatic select(input logic [7:0] cmd);
        rd_cmd_o <= cmd;
        @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the converter status flag bytes
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic                     clock_i = 1'b0;
    logic                     resetn_i = 1'b0;
    cvsf_pkg::cvsf_host_wr_t  host_wr;
    cvsf_pkg::cvsf_comm_evt_t comm_evt = '0;
    logic                     clr, above_on = 1'b0, below_off = 1'b0, die_tsd = 1'b0;
    logic                     boot_fail = 1'b0, ss_fail = 1'b0, drv_ovr = 1'b0, follower = 1'b0;
    logic                     pg_low = 1'b0, reload = 1'b0, sync = 1'b0, alert, stage_ok;
    logic [7:0]               rd_cmd, rd_data, in_st, tmp_st, com_st, ven_st, t_mask = 8'h00;
    logic [7:0]               in_mask = 8'h00, c_mask = 8'h00, v_mask = 8'h00, op_state = 8'h01;
    logic [7:0]               ext_temp = 8'd25, fault_lvl = 8'd100, warn_lvl = 8'd90;
    int                       n_fail = 0;
    int                       num_checks = 0;

    // 200 MHz clock
    always #2.5 clock_i = ~clock_i;

    cvsf_host_model cvsf_host_model_inst (.clock_i(clock_i), .host_wr_o(host_wr),
        .clear_faults_o(clr), .rd_cmd_o(rd_cmd));

    cvsf_status cvsf_status_inst (.clock_i(clock_i), .resetn_i(resetn_i), .host_wr_i(host_wr),
        .clear_faults_i(clr), .rd_cmd_i(rd_cmd), .rd_data_o(rd_data), .input_mask_i(in_mask),
        .temp_mask_i(t_mask), .comm_mask_i(c_mask), .vendor_mask_i(v_mask),
        .analog_supply_above_on_i(above_on), .analog_supply_below_off_i(below_off),
        .ext_temp_i(ext_temp), .overtemperature_fault_level_i(fault_lvl),
        .overtemperature_warning_level_i(warn_lvl), .die_over_thermal_shutdown_i(die_tsd),
        .comm_evt_i(comm_evt), .op_state_i(op_state), .boot_strap_fail_i(boot_fail),
        .soft_start_strap_fail_i(ss_fail), .drive_on_invalid_select_enable_i(drv_ovr),
        .loop_follower_i(follower), .reset_power_good_pin_low_i(pg_low),
        .boot_voltage_reload_req_i(reload), .sync_fault_i(sync), .smbus_alert_o(alert),
        .stage_enable_ok_o(stage_ok), .input_status_o(in_st), .temperature_status_o(tmp_st),
        .communication_status_o(com_st), .vendor_fault_status_o(ven_st));

    // Helpers: wait falling edges, compare, pulse a level for one cycle
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic ck(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask

    task automatic close_out();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Power-up indication is live and sticky only after first turn-on
    task automatic test_input();
        ck(in_st, 8'h10);
        cvsf_host_model_inst.write_byte(8'h7c, 8'h10);
        step(1);
        ck(in_st, 8'h10);
        ck({7'h00, alert}, 8'h00);
        above_on = 1'b1;
        step(2);
        ck(in_st, 8'h00);
        above_on = 1'b0;
        pulse(below_off);
        above_on = 1'b1;
        step(1);
        ck(in_st, 8'h10);
        ck({7'h00, alert}, 8'h01);
        in_mask = 8'h10;
        step(2);
        ck({7'h00, alert}, 8'h00);
        cvsf_host_model_inst.write_byte(8'h7c, 8'hef);
        step(1);
        ck(in_st, 8'h10);
        cvsf_host_model_inst.write_byte(8'h7c, 8'h10);
        step(1);
        ck(in_st, 8'h00);
    endtask

    // Limits at the boundary and clear with and without 20 C of margin
    task automatic test_temp();
        ext_temp = 8'd99;
        step(2);
        ck(tmp_st, 8'h40);
        ext_temp = 8'd100;
        step(2);
        ck(tmp_st, 8'hc0);
        ck({7'h00, alert}, 8'h01);
        t_mask = 8'hc0;
        step(2);
        ck({7'h00, alert}, 8'h00);
        t_mask = 8'h00;
        ext_temp = 8'd81;
        cvsf_host_model_inst.write_byte(8'h7d, 8'hc0);
        step(3);
        ck(tmp_st, 8'hc0);
        ext_temp = 8'd70;
        cvsf_host_model_inst.write_byte(8'h7d, 8'hc0);
        step(3);
        ck(tmp_st, 8'h00);
    endtask

    // Every communication event in turn, the packet check one masked
    task automatic test_comm();
        logic [7:0] exp [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
        c_mask = 8'h20;
        for (int i = 0; i < 5; i++) begin
            comm_evt = cvsf_pkg::cvsf_comm_evt_t'(5'b10000 >> i);
            step(1);
            comm_evt = '0;
            step(1);
            ck(com_st, exp[i]);
            ck({7'h00, alert}, {7'h00, i != 2});
            cvsf_host_model_inst.select(8'h7e);
            ck(rd_data, exp[i]);
            cvsf_host_model_inst.write_byte(8'h7e, exp[i]);
            step(1);
            ck(com_st, 8'h00);
        end
        cvsf_host_model_inst.select(8'h81);
        ck(rd_data, 8'h00);
    endtask

    // Vendor byte: latched, informational and live bits
    task automatic test_vendor();
        pulse(die_tsd);
        ck(ven_st, 8'h80);
        ck({7'h00, alert}, 8'h01);
        cvsf_host_model_inst.write_byte(8'h80, 8'h80);
        v_mask = 8'h80;
        op_state = 8'h00;
        step(1);
        op_state = 8'h03;
        die_tsd = 1'b1;
        step(1);
        op_state = 8'h01;
        die_tsd = 1'b0;
        step(2);
        ck(ven_st, 8'he0);
        ck({7'h00, alert}, 8'h00);
        cvsf_host_model_inst.write_byte(8'h80, 8'h80);
        v_mask = 8'h00;
        pulse(boot_fail);
        ck(ven_st, 8'h70);
        ck({6'h00, alert, stage_ok}, 8'h02);
        drv_ovr = 1'b1;
        step(2);
        ck({7'h00, stage_ok}, 8'h01);
        cvsf_host_model_inst.clear_faults();
        step(1);
        ck(ven_st, 8'h60);
        pulse(ss_fail);
        ck({ven_st[7:1], alert}, 8'h68);
        cvsf_host_model_inst.write_byte(8'h80, 8'h48);
        {pg_low, reload} = 2'b11;
        step(2);
        ck(ven_st, 8'h64);
        {reload, sync} = 2'b01;
        step(2);
        ck({ven_st[7:1], alert}, 8'h60);
        ck(ven_st, 8'h61);
        {pg_low, sync, follower, boot_fail, ss_fail} = 5'b00111;
        step(3);
        ck(ven_st, 8'h62);
    endtask

    // Reset held for six cycles, then the scenarios in order
    initial begin
        step(6);
        ck(in_st, 8'h10);
        ck(tmp_st | com_st | ven_st | {6'h00, alert, stage_ok}, 8'h00);
        resetn_i = 1'b1;
        step(2);
        test_input();
        test_temp();
        test_comm();
        test_vendor();
        close_out();
    end

    // Watchdog well beyond the roughly 85 cycles the scenarios need
    initial begin
        #(2000 * 5);
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
